// file: rtl/sram_ddr_defs.vh
// Constants for the separate-port double-data-rate burst memory.
// Assumes it is included by bare name from the design files.
`ifndef SRAM_DDR_DEFS_VH
`define SRAM_DDR_DEFS_VH

// ==========================================================================
// Array geometry.
`define SD_DATA_W 36
`define SD_ADDR_W 19
`define SD_LANE_W 9
`define SD_LANES 4
`define SD_BURST_W 2

// ==========================================================================
// Read latency in data beats (two beats per input clock period).
`define SD_LAT_LONG_BEATS 5
`define SD_LAT_SHORT_BEATS 2

`endif

// file: rtl/sram_ddr_array.v
// Storage array with one byte-lane write port and one registered read port.
// Assumes write and read requests come from logic on the same clock.
`timescale 1ns/100ps
`include "sram_ddr_defs.vh"

module sram_ddr_array #(
  parameter DW = `SD_DATA_W,
  parameter AW = `SD_ADDR_W + `SD_BURST_W,
  parameter LW = `SD_LANE_W,
  parameter NL = `SD_LANES
) (
  input wire i_clk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [NL-1:0] i_wlane_n,
  input wire i_re,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer l;

  // ==========================================================================
  // Lane writes and registered read with write-first forwarding.
  always @(posedge i_clk) begin
    for (l = 0; l < NL; l = l + 1) begin
      if (i_we && !i_wlane_n[l]) begin
        mem[i_waddr][l*LW +: LW] <= i_wdata[l*LW +: LW];
      end
    end
    if (i_re) begin
      o_rdata <= mem[i_raddr];
      for (l = 0; l < NL; l = l + 1) begin
        if (i_we && !i_wlane_n[l] && (i_waddr == i_raddr)) begin
          o_rdata[l*LW +: LW] <= i_wdata[l*LW +: LW];
        end
      end
    end
  end

endmodule

// file: rtl/sram_ddr_port.v
// Device side of a separate-port double-data-rate four-word burst memory.
// Assumes both input clocks and all pins arrive asynchronously to i_clk.
//
// Notes on behaviour
// - Shared address: read slot, then write slot.
// - Each address holds a four-word burst.
// - One data beat per rising edge of either clock.
// - Read and write data ports run independently; the address alternates read and write slots.
// - Inputs captured only on input clock rising edges.
// - Read data registered on input clock rising edges.
// - PLL enabled: data 2.5 cycles after address.
// - PLL disabled: data one cycle after address.
// - Valid flag high while read beats are driven.
// - Complementary echo clocks accompany read data.
// - Captured writes finish without controller help.
// - Separate read and write port selects.
// - Reads always return the newest written data.
// - Write select low starts write, high ignores data.
// - Read select starts burst; deselect tri-states after edge.
// - Per-lane byte selects mask nine-bit lanes.
// - Nineteen-bit address ignored on deselected port.
`timescale 1ns/100ps
`include "sram_ddr_defs.vh"

module sram_ddr_port #(
  parameter DW = `SD_DATA_W,
  parameter AW = `SD_ADDR_W,
  parameter LAT_LONG = `SD_LAT_LONG_BEATS,
  parameter LAT_SHORT = `SD_LAT_SHORT_BEATS
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_k_clk,
  input wire i_k_clk_n,
  input wire [AW-1:0] i_addr,
  input wire i_read_port_select_n,
  input wire i_write_port_select_n,
  input wire [`SD_LANES-1:0] i_byte_write_select_n,
  input wire [DW-1:0] i_data,
  input wire i_pll_disable_n,
  output wire [DW-1:0] o_q,
  output wire o_q_oe,
  output wire o_read_data_valid,
  output wire o_echo_clock,
  output wire o_echo_clock_n
);

  localparam MW = AW + `SD_BURST_W;
  localparam NL = `SD_LANES;

  // ==========================================================================
  // Two-stage synchronisers and edge finders.
  reg k_s1_ff, k_s2_ff, k_s3_ff;
  reg kn_s1_ff, kn_s2_ff, kn_s3_ff;
  reg rps_s1_ff, rps_s2_ff, wps_s1_ff, wps_s2_ff, pll_s1_ff, pll_s2_ff;
  reg [AW-1:0] addr_s1_ff, addr_s2_ff;
  reg [DW-1:0] data_s1_ff, data_s2_ff;
  reg [NL-1:0] bws_s1_ff, bws_s2_ff;

  // Clock samplers run through reset, so no false edge follows its release.
  always @(posedge i_clk) begin
    k_s1_ff <= i_k_clk;
    k_s2_ff <= k_s1_ff;
    k_s3_ff <= k_s2_ff;
    kn_s1_ff <= i_k_clk_n;
    kn_s2_ff <= kn_s1_ff;
    kn_s3_ff <= kn_s2_ff;
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rps_s1_ff <= 1'b1;
      rps_s2_ff <= 1'b1;
      wps_s1_ff <= 1'b1;
      wps_s2_ff <= 1'b1;
      pll_s1_ff <= 1'b1;
      pll_s2_ff <= 1'b1;
      addr_s1_ff <= {AW{1'b0}};
      addr_s2_ff <= {AW{1'b0}};
      data_s1_ff <= {DW{1'b0}};
      data_s2_ff <= {DW{1'b0}};
      bws_s1_ff <= {NL{1'b1}};
      bws_s2_ff <= {NL{1'b1}};
    end else begin
      rps_s1_ff <= i_read_port_select_n;
      rps_s2_ff <= rps_s1_ff;
      wps_s1_ff <= i_write_port_select_n;
      wps_s2_ff <= wps_s1_ff;
      pll_s1_ff <= i_pll_disable_n;
      pll_s2_ff <= pll_s1_ff;
      addr_s1_ff <= i_addr;
      addr_s2_ff <= addr_s1_ff;
      data_s1_ff <= i_data;
      data_s2_ff <= data_s1_ff;
      bws_s1_ff <= i_byte_write_select_n;
      bws_s2_ff <= bws_s1_ff;
    end
  end

  wire k_rise = k_s2_ff & ~k_s3_ff;
  wire kn_rise = kn_s2_ff & ~kn_s3_ff;
  wire beat = k_rise | kn_rise;

  // ==========================================================================
  // Address slot: even primary edges carry reads, odd ones writes.
  reg slot_ff;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      slot_ff <= 1'b0;
    end else if (k_rise) begin
      slot_ff <= ~slot_ff;
    end
  end

  wire rd_take = k_rise & ~slot_ff & ~rps_s2_ff;
  wire wr_take = k_rise & slot_ff & ~wps_s2_ff;

  // ==========================================================================
  // Read latency pipeline, counted in beats.
  reg [LAT_LONG-1:0] rd_pipe_ff;
  reg [AW*LAT_LONG-1:0] rd_apipe_ff;
  reg [2:0] rd_cnt_ff;
  reg [`SD_BURST_W-1:0] rd_idx_ff;
  reg [AW-1:0] rd_base_ff;
  reg [MW-1:0] raddr;
  reg re;
  reg [AW-1:0] start_addr;
  reg rd_start;

  always @* begin
    rd_start = pll_s2_ff ? rd_pipe_ff[LAT_LONG-1] : rd_pipe_ff[LAT_SHORT-1];
    start_addr = pll_s2_ff ? rd_apipe_ff[AW*LAT_LONG-1 -: AW] : rd_apipe_ff[AW*LAT_SHORT-1 -: AW];
    re = beat & (rd_start | (rd_cnt_ff != 3'h0));
    raddr = rd_start ? {start_addr, 2'h0} : {rd_base_ff, rd_idx_ff};
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_pipe_ff <= {LAT_LONG{1'b0}};
      rd_apipe_ff <= {AW*LAT_LONG{1'b0}};
      rd_cnt_ff <= 3'h0;
      rd_idx_ff <= 2'h0;
      rd_base_ff <= {AW{1'b0}};
    end else if (beat) begin
      rd_pipe_ff <= {rd_pipe_ff[LAT_LONG-2:0], rd_take};
      rd_apipe_ff <= {rd_apipe_ff[AW*(LAT_LONG-1)-1:0], addr_s2_ff};
      if (rd_start) begin
        rd_base_ff <= start_addr;
        rd_idx_ff <= 2'h1;
        rd_cnt_ff <= 3'h3;
      end else if (rd_cnt_ff != 3'h0) begin
        rd_idx_ff <= rd_idx_ff + 2'h1;
        rd_cnt_ff <= rd_cnt_ff - 3'h1;
      end
    end
  end

  // ==========================================================================
  // Write burst, finished by the block itself after capture.
  reg [2:0] wr_cnt_ff;
  reg [`SD_BURST_W-1:0] wr_idx_ff;
  reg [AW-1:0] wr_base_ff;
  reg [MW-1:0] waddr;
  reg we;

  always @* begin
    we = beat & (wr_take | (wr_cnt_ff != 3'h0));
    waddr = wr_take ? {addr_s2_ff, 2'h0} : {wr_base_ff, wr_idx_ff};
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_cnt_ff <= 3'h0;
      wr_idx_ff <= 2'h0;
      wr_base_ff <= {AW{1'b0}};
    end else if (beat) begin
      if (wr_take) begin
        wr_base_ff <= addr_s2_ff;
        wr_idx_ff <= 2'h1;
        wr_cnt_ff <= 3'h3;
      end else if (wr_cnt_ff != 3'h0) begin
        wr_idx_ff <= wr_idx_ff + 2'h1;
        wr_cnt_ff <= wr_cnt_ff - 3'h1;
      end
    end
  end

  // ==========================================================================
  // Array, written and read independently on each beat.
  wire [DW-1:0] rdata;

  sram_ddr_array #(
    .DW(DW),
    .AW(MW),
    .LW(`SD_LANE_W),
    .NL(NL)
  ) u_array (
    .i_clk(i_clk),
    .i_we(we),
    .i_waddr(waddr),
    .i_wdata(data_s2_ff),
    .i_wlane_n(bws_s2_ff),
    .i_re(re),
    .i_raddr(raddr),
    .o_rdata(rdata)
  );

  // ==========================================================================
  // Output registers, valid flag and echo clocks.
  reg beat_d_ff, k_d_ff, re_d_ff;
  reg [DW-1:0] q_ff;
  reg oe_ff, valid_ff, cq_ff, cqn_ff;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      beat_d_ff <= 1'b0;
      k_d_ff <= 1'b0;
      re_d_ff <= 1'b0;
      q_ff <= {DW{1'b0}};
      oe_ff <= 1'b0;
      valid_ff <= 1'b0;
      cq_ff <= 1'b0;
      cqn_ff <= 1'b0;
    end else begin
      beat_d_ff <= beat;
      k_d_ff <= k_rise;
      re_d_ff <= re;
      cq_ff <= k_s2_ff;
      cqn_ff <= kn_s2_ff;
      if (beat_d_ff) begin
        valid_ff <= re_d_ff;
        if (re_d_ff) begin
          q_ff <= rdata;
          oe_ff <= 1'b1;
        end else if (k_d_ff) begin
          oe_ff <= 1'b0;
        end
      end
    end
  end

  assign o_q = q_ff;
  assign o_q_oe = oe_ff;
  assign o_read_data_valid = valid_ff;
  assign o_echo_clock = cq_ff;
  assign o_echo_clock_n = cqn_ff;

endmodule

// file: sim/sram_ddr_port_sva.sv
// Assertion checker for the burst memory port.
// Assumes it is bound to sram_ddr_port and sees only its ports.
`timescale 1ns/100ps
module sram_ddr_port_sva #(
  parameter DW = 36,
  parameter AW = 19
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_k_clk,
  input wire i_k_clk_n,
  input wire [AW-1:0] i_addr,
  input wire i_read_port_select_n,
  input wire i_write_port_select_n,
  input wire [3:0] i_byte_write_select_n,
  input wire [DW-1:0] i_data,
  input wire i_pll_disable_n,
  input wire [DW-1:0] o_q,
  input wire o_q_oe,
  input wire o_read_data_valid,
  input wire o_echo_clock,
  input wire o_echo_clock_n
);
  // ==========================================================================
  // Output timing properties.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_burst;
    o_read_data_valid [*8] ##1 o_read_data_valid [*8] ##1 o_read_data_valid [*2] ##[1:3] !o_read_data_valid;
  endsequence
  AST_ECHO_K: assert property (!$past(i_sys_rst, 3) |-> o_echo_clock == $past(i_k_clk, 3))
    else $error("echo clock wrong");
  AST_ECHO_KN: assert property (!$past(i_sys_rst, 3) |-> o_echo_clock_n == $past(i_k_clk_n, 3))
    else $error("inverted echo clock wrong");
  AST_VALID_OE: assert property (o_read_data_valid |-> o_q_oe)
    else $error("valid without drive");
  AST_RST_QUIET: assert property ($past(i_sys_rst) |-> !o_q_oe && !o_read_data_valid && o_q == 36'h0)
    else $error("outputs active after reset");
  AST_BURST: assert property ($rose(o_read_data_valid) |-> s_burst)
    else $error("burst length wrong");
  AST_OE_DROP: assert property ($fell(o_read_data_valid) |-> ##[1:12] !o_q_oe)
    else $error("drive not released");
  AST_LAT_LONG: assert property ($rose(o_read_data_valid) && i_pll_disable_n |-> !$past(i_read_port_select_n, 30))
    else $error("long latency wrong");
  AST_LAT_SHORT: assert property ($rose(o_read_data_valid) && !i_pll_disable_n |-> !$past(i_read_port_select_n, 15))
    else $error("short latency wrong");
endmodule

// file: sim/ctl_model.sv
// Memory controller model driving the input clocks, address, selects and data.
// Assumes the testbench calls its wr and rd tasks one of each at a time.
`timescale 1ns/100ps
module ctl_model (
  input wire i_sys_rst,
  input wire [35:0] i_q,
  input wire i_q_oe,
  input wire i_qv,
  output reg o_k,
  output wire o_kn,
  output reg [18:0] o_addr,
  output reg o_rps_n,
  output reg o_wps_n,
  output reg [3:0] o_bws_n,
  output reg [35:0] o_d,
  output reg o_pll
);
  // ==========================================================================
  // Clocks and slot tracking.
  reg rd_slot;
  assign o_kn = ~o_k;
  initial begin
    {o_k, o_addr, o_rps_n, o_wps_n, o_bws_n, o_d, o_pll} = {1'b0, 19'h0, 2'h3, 4'hF, 36'h0, 1'b1};
    #20.3 o_k = 1'b1;
    forever #40 o_k = ~o_k;
  end
  always @(posedge o_k) rd_slot <= i_sys_rst ? 1'b1 : ~rd_slot;
  task automatic set_pll(input logic v);
    o_pll = v;
  endtask
  task automatic wr(input logic sel, input logic [18:0] a, input logic [143:0] dd, input logic [15:0] m);
    integer j;
    begin
      @(negedge o_k);
      while (rd_slot) @(negedge o_k);
      #20 {o_wps_n, o_addr} = {~sel, a};
      for (j = 0; j < 4; j = j + 1) begin
        {o_d, o_bws_n} = {dd[36*j +: 36], m[4*j +: 4]};
        if (j % 2) @(posedge o_kn); else @(posedge o_k);
        #20;
        if (j == 0) {o_wps_n, o_addr} = {1'b1, ~a};
      end
      {o_d, o_bws_n} = ~{o_d, o_bws_n};
    end
  endtask
  task automatic rd(input logic [18:0] a, output logic [179:0] q, output logic [4:0] v, output logic [4:0] oe);
    integer j;
    begin
      @(negedge o_k);
      while (!rd_slot) @(negedge o_k);
      #20 {o_rps_n, o_addr} = {1'b0, a};
      @(posedge o_k);
      #20 {o_rps_n, o_addr} = {1'b1, ~a};
      #(o_pll ? 240 : 120);
      for (j = 0; j < 5; j = j + 1) begin
        {q[36*j +: 36], v[j], oe[j]} = {i_q, i_qv, i_q_oe};
        #40;
      end
    end
  endtask
endmodule

// file: sim/testbench.sv
// Self-checking testbench for the burst memory port.
// Assumes ctl_model and the checker are compiled before it.
`timescale 1ns/100ps
module testbench;
  // ==========================================================================
  // Design, controller model and scoreboard.
  reg i_clk = 1'b0;
  reg i_sys_rst = 1'b1;
  wire k, kn, rps_n, wps_n, pll, oe, qv, e, en;
  wire [18:0] addr;
  wire [3:0] bws_n;
  wire [35:0] d, q;
  integer err_total = 0;
  integer n_tests = 0;
  integer i;
  logic [35:0] mem [0:31];
  logic [70:0] rows [3] = '{{19'h00001, 36'hA5A5A5A5A, 16'h0000}, {19'h7FFFF, 36'h123456789, 16'h0000},
    {19'h00001, 36'hFFFFFFFFF, 16'h8421}};
  always #4 i_clk = ~i_clk;
  sram_ddr_port #(.AW(19)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_k_clk(k), .i_k_clk_n(kn),
    .i_addr(addr), .i_read_port_select_n(rps_n), .i_write_port_select_n(wps_n), .i_byte_write_select_n(bws_n),
    .i_data(d), .i_pll_disable_n(pll), .o_q(q), .o_q_oe(oe), .o_read_data_valid(qv), .o_echo_clock(e),
    .o_echo_clock_n(en));
  ctl_model i_ctl (.i_sys_rst(i_sys_rst), .i_q(q), .i_q_oe(oe), .i_qv(qv), .o_k(k), .o_kn(kn), .o_addr(addr),
    .o_rps_n(rps_n), .o_wps_n(wps_n), .o_bws_n(bws_n), .o_d(d), .o_pll(pll));
  task check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task put(input logic [18:0] a, input logic [143:0] dd, input logic [15:0] m);
    integer k, l;
    for (k = 0; k < 4; k = k + 1)
      for (l = 0; l < 4; l = l + 1)
        if (!m[4*k+l]) mem[{a[2:0], k[1:0]}][9*l +: 9] = dd[36*k+9*l +: 9];
  endtask
  task rdchk(input logic [18:0] a);
    logic [179:0] rq;
    logic [4:0] v, o;
    integer k;
    i_ctl.rd(a, rq, v, o);
    for (k = 0; k < 4; k = k + 1) check(rq[36*k +: 36], mem[{a[2:0], k[1:0]}]);
    check({31'h0, v}, 36'hF);
    check({32'h0, o[3:0]}, 36'hF);
  endtask
  function automatic logic [143:0] beats(input logic [35:0] s);
    beats = {s + 36'h3, s + 36'h2, s + 36'h1, s};
  endfunction
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total = err_total + 1;
    conclude;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    check(q, 36'h0);
    check({32'h0, oe, qv, e, en}, 36'h0);
    i_sys_rst = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      i_ctl.wr(1'b1, rows[i][70:52], beats(rows[i][51:16]), rows[i][15:0]);
      put(rows[i][70:52], beats(rows[i][51:16]), rows[i][15:0]);
      rdchk(rows[i][70:52]);
    end
    i_ctl.wr(1'b0, 19'h00001, beats(36'h5A5A5A5A5), 16'h0000);
    rdchk(19'h00001);
    fork
      i_ctl.wr(1'b1, 19'h00002, beats(36'h0F0F0F0F0), 16'h0000);
      rdchk(19'h7FFFF);
    join
    put(19'h00002, beats(36'h0F0F0F0F0), 16'h0000);
    i_ctl.set_pll(1'b0);
    rdchk(19'h00002);
    put(19'h00003, beats(36'h3C3C3C3C3), 16'h0000);
    fork
      i_ctl.wr(1'b1, 19'h00003, beats(36'h3C3C3C3C3), 16'h0000);
      rdchk(19'h00003);
    join
    @(posedge i_clk);
    #1 i_sys_rst = 1'b1;
    i_ctl.set_pll(1'b1);
    repeat (20) @(posedge i_clk);
    #1;
    check(q, 36'h0);
    check({32'h0, oe, qv, e, en}, 36'h0);
    @(negedge k);
    @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    rdchk(19'h00001);
    conclude;
  end
endmodule
bind sram_ddr_port sram_ddr_port_sva #(.DW(DW), .AW(AW)) i_chk (.i_clk, .i_sys_rst, .i_k_clk, .i_k_clk_n,
  .i_addr, .i_read_port_select_n, .i_write_port_select_n, .i_byte_write_select_n, .i_data, .i_pll_disable_n,
  .o_q, .o_q_oe, .o_read_data_valid, .o_echo_clock, .o_echo_clock_n);
